// [rtl/rgb_led_pkg.sv]
// Constants for the color LED output control block
package rgb_led_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] COLOR_ADDR  = 8'h01;
  localparam logic [7:0] SCALE_ADDR  = 8'h02;
  localparam logic [7:0] GPIO_ADDR   = 8'h06;
  localparam logic [7:0] FLASH_ADDR  = 8'h07;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  // Control register fields
  localparam int INT_MOD_BIT   = 7;
  localparam int COLOR_EN_BIT  = 6;
  localparam int SINK_MODE_BIT = 5;
  localparam int ON_BITS_LSB   = 1;
  // Current scale fields
  localparam int RED_SCALE_LSB   = 4;
  localparam int GREEN_SCALE_LSB = 2;
  localparam int BLUE_SCALE_LSB  = 0;
  localparam logic [1:0] FULL_SCALE = 2'h3;
  // Pin modulation enable in the GPIO control register
  localparam int PIN_MOD_BIT = 0;
  // Flash register fields and the status register tripped bit
  localparam int FLASH_EN_BIT   = 7;
  localparam int EXT_SEL_LSB    = 4;
  localparam int SAFETY_EN_LSB  = 0;
  localparam int TRIPPED_BIT    = 0;
  // Brightness field of the color register
  localparam int BRIGHT_LSB = 1;
  // Reset values; outputs start in switch mode
  localparam logic [7:0] CTRL_RESET  = 8'h20;
  localparam logic [7:0] COLOR_RESET = 8'h00;
  localparam logic [7:0] SCALE_RESET = 8'h00;
  localparam logic [7:0] GPIO_RESET  = 8'h00;
  localparam logic [7:0] FLASH_RESET = 8'h00;
  // Timing
  localparam longint CLK_HZ       = 25000000;
  localparam longint MOD_FREQ_HZ  = 20000;
  localparam longint SAFETY_TIME_MS = 1000;
  localparam longint MOD_PERIOD_CYC = CLK_HZ / MOD_FREQ_HZ;
  localparam longint SAFETY_CYC = CLK_HZ * SAFETY_TIME_MS / 1000;
  // Flash sequence, Gray along idle-armed-pulse-spent
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ARMED = 2'b01,
    FL_PULSE = 2'b11,
    FL_SPENT = 2'b10
  } flash_state_t;
endpackage

// [rtl/rgb_led_flash_control.sv]
// Color LED output control with modulation, flash and safety timer
`timescale 1ns/1ns
module rgb_led_flash_control #(
  parameter longint SAFETY_CYCLES = rgb_led_pkg::SAFETY_CYC,
  parameter longint MOD_CYCLES    = rgb_led_pkg::MOD_PERIOD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic       modPin,
  output logic            redOutput,
  output logic            greenOutput,
  output logic            blueOutput,
  output logic      [1:0] redScale,
  output logic      [1:0] greenScale,
  output logic      [1:0] blueScale,
  output logic            sinkSwitchMode
);
  if (SAFETY_CYCLES < 2 || SAFETY_CYCLES > 64'h1ffffff)
  begin : g_bad_safety
    $error("SAFETY_CYCLES out of range");
  end
  if (MOD_CYCLES < 8 || MOD_CYCLES > 64'h7ff)
  begin : g_bad_mod
    $error("MOD_CYCLES out of range");
  end

  localparam logic [24:0] SAFE_LAST = 25'(SAFETY_CYCLES - 1);
  localparam logic [10:0] MOD_LAST  = 11'(MOD_CYCLES - 1);
  localparam logic [10:0] MOD_STEP  = 11'(MOD_CYCLES / 8);

  //////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl;
  logic [7:0] color;
  logic [7:0] scale;
  logic [7:0] gpioCtrl;
  logic [7:0] flashCtrl;
  logic       tripped;
  logic [7:0] next_rdData;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl      <= rgb_led_pkg::CTRL_RESET;
      color     <= rgb_led_pkg::COLOR_RESET;
      scale     <= rgb_led_pkg::SCALE_RESET;
      gpioCtrl  <= rgb_led_pkg::GPIO_RESET;
      flashCtrl <= rgb_led_pkg::FLASH_RESET;
    end
    else if (regWr)
    begin
      case (regAddr)
        rgb_led_pkg::CTRL_ADDR:  ctrl <= regWrData;
        rgb_led_pkg::COLOR_ADDR: color <= regWrData;
        rgb_led_pkg::SCALE_ADDR: scale <= regWrData;
        rgb_led_pkg::GPIO_ADDR:  gpioCtrl <= regWrData;
        rgb_led_pkg::FLASH_ADDR: flashCtrl <= regWrData;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (regAddr)
      rgb_led_pkg::CTRL_ADDR:   next_rdData = ctrl;
      rgb_led_pkg::COLOR_ADDR:  next_rdData = color;
      rgb_led_pkg::SCALE_ADDR:  next_rdData = scale;
      rgb_led_pkg::GPIO_ADDR:   next_rdData = gpioCtrl;
      rgb_led_pkg::FLASH_ADDR:  next_rdData = flashCtrl;
      rgb_led_pkg::STATUS_ADDR: next_rdData = {7'h00, tripped};
      default:                  next_rdData = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else if (regRd)
      regRdData <= next_rdData;
  end

  //////////////////////////////////////////////////////////////////////
  // Decoded controls
  logic       intModEn;
  logic       colorEn;
  logic       pinMod;
  logic       flashEn;
  logic [2:0] onBits;
  logic [2:0] extSel;
  logic [2:0] safetyEn;
  logic       anySafe;

  assign intModEn = ctrl[rgb_led_pkg::INT_MOD_BIT];
  assign colorEn  = ctrl[rgb_led_pkg::COLOR_EN_BIT];
  assign onBits   = ctrl[rgb_led_pkg::ON_BITS_LSB +: 3];
  assign pinMod   = gpioCtrl[rgb_led_pkg::PIN_MOD_BIT] & colorEn;
  assign flashEn  = flashCtrl[rgb_led_pkg::FLASH_EN_BIT];
  assign extSel   = flashCtrl[rgb_led_pkg::EXT_SEL_LSB +: 3];
  assign safetyEn = flashCtrl[rgb_led_pkg::SAFETY_EN_LSB +: 3];
  assign anySafe  = |safetyEn;

  //////////////////////////////////////////////////////////////////////
  // Internal modulation waveform
  logic [10:0] modPhase;
  logic        intWave;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      modPhase <= 11'h000;
    else if (modPhase == MOD_LAST)
      modPhase <= 11'h000;
    else
      modPhase <= modPhase + 11'h001;
  end

  assign intWave = modPhase <
    11'(MOD_STEP * color[rgb_led_pkg::BRIGHT_LSB +: 3]);

  //////////////////////////////////////////////////////////////////////
  // Flash sequence
  rgb_led_pkg::flash_state_t flashState;

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !flashEn)
      flashState <= rgb_led_pkg::FL_IDLE;
    else
    begin
      case (flashState)
        rgb_led_pkg::FL_IDLE:
          if (!modPin)
            flashState <= rgb_led_pkg::FL_ARMED;
        rgb_led_pkg::FL_ARMED:
          if (modPin && pinMod)
            flashState <= rgb_led_pkg::FL_PULSE;
        rgb_led_pkg::FL_PULSE:
          if (!modPin)
            flashState <= rgb_led_pkg::FL_SPENT;
        rgb_led_pkg::FL_SPENT:
          flashState <= rgb_led_pkg::FL_SPENT;
        default:
          flashState <= rgb_led_pkg::FL_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Safety timer
  logic [24:0] safetyCount;
  logic        safetyRun;
  logic        scaleAccess;

  assign scaleAccess = (regWr || regRd) &&
                       regAddr == rgb_led_pkg::SCALE_ADDR;
  assign safetyRun = anySafe && !tripped &&
                     (!flashEn || modPin);

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !anySafe)
      safetyCount <= 25'h0000000;
    else if (!tripped && !flashEn && scaleAccess)
      safetyCount <= 25'h0000000;
    else if (safetyRun && safetyCount != SAFE_LAST)
      safetyCount <= safetyCount + 25'h0000001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !anySafe)
      tripped <= 1'b0;
    else if (safetyRun && safetyCount == SAFE_LAST)
      tripped <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // Per-channel output logic, index 2 red, 1 green, 0 blue
  logic [5:0] scaleFields;
  logic [2:0] chOn;
  logic [5:0] chScale;
  logic [2:0] safeOff;

  assign scaleFields = {scale[rgb_led_pkg::RED_SCALE_LSB +: 2],
                        scale[rgb_led_pkg::GREEN_SCALE_LSB +: 2],
                        scale[rgb_led_pkg::BLUE_SCALE_LSB +: 2]};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_ch
      logic next_on;
      logic [1:0] next_scale;
      assign safeOff[ch] = tripped & safetyEn[ch];
      always_comb
      begin
        next_on    = 1'b0;
        next_scale = scaleFields[2*ch +: 2];
        if (colorEn && pinMod && extSel[ch] && flashEn)
        begin
          case (flashState)
            rgb_led_pkg::FL_PULSE:
            begin
              next_on    = 1'b1;
              next_scale = rgb_led_pkg::FULL_SCALE;
            end
            rgb_led_pkg::FL_ARMED: next_on = onBits[ch];
            default:               next_on = 1'b0;
          endcase
        end
        else if (colorEn && onBits[ch])
        begin
          if (pinMod && extSel[ch])
            next_on = modPin & (!intModEn || intWave);
          else
            next_on = !intModEn || intWave;
        end
        if (safeOff[ch])
          next_on = 1'b0;
      end
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          chOn[ch]          <= 1'b0;
          chScale[2*ch +: 2] <= rgb_led_pkg::SCALE_RESET[1:0];
        end
        else
        begin
          chOn[ch]          <= next_on;
          chScale[2*ch +: 2] <= next_scale;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      sinkSwitchMode <= 1'b1;
    else
      sinkSwitchMode <= ctrl[rgb_led_pkg::SINK_MODE_BIT];
  end

  assign redOutput   = chOn[2];
  assign greenOutput = chOn[1];
  assign blueOutput  = chOn[0];
  assign redScale    = chScale[5:4];
  assign greenScale  = chScale[3:2];
  assign blueScale   = chScale[1:0];

  //////////////////////////////////////////////////////////////////////
  // Checks, on the red channel, the sink mode output, the safety counter and all tripped outputs
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic redPlain;
  assign redPlain = colorEn && onBits[2] && !safeOff[2] && !intModEn;

  chk_direct_on: assert property (
    redPlain && !(pinMod && extSel[2]) |=> redOutput)
    else $error("direct on output not driven");
  chk_sink_mode: assert property (
    regWr && regAddr == rgb_led_pkg::CTRL_ADDR |-> ##2
    sinkSwitchMode == $past(regWrData[rgb_led_pkg::SINK_MODE_BIT], 2))
    else $error("sink mode not following control");
  chk_scale_field: assert property (
    regWr && regAddr == rgb_led_pkg::SCALE_ADDR && !flashEn |-> ##2
    redScale == $past(regWrData[5:4], 2))
    else $error("red scale field wrong");
  chk_ext_direct: assert property (
    redPlain && pinMod && extSel[2] && !flashEn |=>
    redOutput == $past(modPin))
    else $error("output not following pin");
  chk_ext_and: assert property (
    colorEn && onBits[2] && !safeOff[2] && intModEn && pinMod &&
    extSel[2] && !flashEn |=> redOutput == $past(modPin && intWave))
    else $error("pin and waveform not combined");
  chk_unselected_on: assert property (
    redPlain && !extSel[2] |=> redOutput)
    else $error("unselected output not on");
  chk_flash_full: assert property (
    flashState == rgb_led_pkg::FL_PULSE && flashEn && colorEn && pinMod &&
    extSel[2] && !safeOff[2] |=> redOutput && redScale == rgb_led_pkg::FULL_SCALE)
    else $error("flash not at full scale");
  chk_flash_end: assert property (
    flashState == rgb_led_pkg::FL_PULSE && !modPin && flashEn &&
    colorEn && pinMod && extSel[2] |=> ##1 !redOutput)
    else $error("flash output not shut off");
  chk_safety_off: assert property (
    tripped |=> (chOn & $past(safetyEn)) == 3'h0)
    else $error("tripped output still on");
  chk_counter_clear: assert property (
    !anySafe |=> safetyCount == 25'h0000000 && !tripped)
    else $error("safety counter not cleared");
  chk_flash_hold: assert property (
    flashEn && !modPin && !tripped && anySafe && !$fell(anySafe)
    |=> $stable(safetyCount))
    else $error("safety counter ran with pin low");

  cov_trip: cover property ($rose(tripped));
  cov_flash: cover property (flashState == rgb_led_pkg::FL_PULSE ##1
    flashState == rgb_led_pkg::FL_SPENT);
  cov_ext: cover property (pinMod && extSel[2] && $rose(redOutput));
endmodule

// [sim/rgb_led_pulse_source.sv]
// Pulse source model for the shared modulation and flash trigger pin
`timescale 1ns/1ns
module rgb_led_pulse_source (
  output logic modPin
);
  // Pin is driven at all times and rests low
  initial
    modPin = 1'b0;
  // Called just after a falling edge of the clock
  task automatic drive(input logic level);
    modPin = level;
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the color LED output control block
`timescale 1ns/1ns
module tb;
  logic       core_clk;
  logic       nrst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdData;
  logic       modPin;
  logic       redOutput;
  logic       greenOutput;
  logic       blueOutput;
  logic [1:0] redScale;
  logic [1:0] greenScale;
  logic [1:0] blueScale;
  logic       sinkSwitchMode;
  logic [7:0] rdv;
  int         ones;
  int         nMismatch;
  int         nCompared;

  rgb_led_flash_control #(.SAFETY_CYCLES(100), .MOD_CYCLES(8)) i_dut (
    .core_clk      (core_clk),
    .nrst          (nrst),
    .regAddr       (regAddr),
    .regWrData     (regWrData),
    .regWr         (regWr),
    .regRd         (regRd),
    .regRdData     (regRdData),
    .modPin        (modPin),
    .redOutput     (redOutput),
    .greenOutput   (greenOutput),
    .blueOutput    (blueOutput),
    .redScale      (redScale),
    .greenScale    (greenScale),
    .blueScale     (blueScale),
    .sinkSwitchMode(sinkSwitchMode)
  );
  rgb_led_pulse_source i_pulse (
    .modPin(modPin)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    cyc(1);
    regWr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr = a;
    regRd = 1'b1;
    cyc(1);
    regRd = 1'b0;
    rdv = regRdData;
    cyc(1);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk("register", exp, rdv);
  endtask
  task automatic chkLeds(input logic [2:0] exp);
    chk("outputs", {5'h00, exp}, {5'h00, redOutput, greenOutput, blueOutput});
  endtask
  task automatic countRed(input int n);
    ones = 0;
    repeat (n)
    begin
      cyc(1);
      ones += int'(redOutput === 1'b1);
    end
  endtask
  // Pulse the trigger and look at the outputs during and after it
  task automatic flashShot(input logic [2:0] exp);
    i_pulse.drive(1'b1);
    cyc(3);
    chkLeds(exp);
    if (exp != 3'h0)
      chk("scale", 8'h3f, {2'h0, redScale, greenScale, blueScale});
    i_pulse.drive(1'b0);
    cyc(3);
    chkLeds(3'h0);
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    nMismatch++;
    tally_and_finish();
  end

  initial
  begin
    nrst = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    nMismatch = 0;
    nCompared = 0;
    cyc(3);
    nrst = 1'b1;
    chkReg(rgb_led_pkg::CTRL_ADDR, rgb_led_pkg::CTRL_RESET);
    chk("sink mode", 8'h01, {7'h00, sinkSwitchMode});
    chkReg(rgb_led_pkg::SCALE_ADDR, 8'h00);
    wr(rgb_led_pkg::STATUS_ADDR, 8'hff);
    chkReg(rgb_led_pkg::STATUS_ADDR, 8'h00);
    chkReg(8'h05, 8'h00);
    chkLeds(3'h0);
    $display("Test reset done");
    wr(rgb_led_pkg::COLOR_ADDR, 8'hff);
    for (int i = 0; i < 3; i++)
    begin
      wr(rgb_led_pkg::CTRL_ADDR, 8'h40 | (8'h02 << i));
      cyc(2);
      chkLeds(3'h1 << i);
    end
    wr(rgb_led_pkg::CTRL_ADDR, 8'h4e);
    cyc(2);
    chk("sink mode", 8'h00, {7'h00, sinkSwitchMode});
    for (int c = 0; c < 4; c++)
    begin
      wr(rgb_led_pkg::SCALE_ADDR, {2'h0, 2'(c), 2'(c + 1), 2'(c + 2)});
      cyc(2);
      chk("scale", {2'h0, 2'(c), 2'(c + 1), 2'(c + 2)}, {2'h0, redScale, greenScale, blueScale});
    end
    wr(rgb_led_pkg::COLOR_ADDR, 8'h00);
    wr(rgb_led_pkg::CTRL_ADDR, 8'h40);
    wr(rgb_led_pkg::SCALE_ADDR, 8'h00);
    wr(rgb_led_pkg::CTRL_ADDR, 8'h4e);
    cyc(2);
    chkLeds(3'h7);
    chk("scale", 8'h00, {2'h0, redScale, greenScale, blueScale});
    wr(rgb_led_pkg::SCALE_ADDR, 8'h3f);
    cyc(2);
    chk("scale", 8'h3f, {2'h0, redScale, greenScale, blueScale});
    wr(rgb_led_pkg::CTRL_ADDR, 8'h40);
    cyc(2);
    chkLeds(3'h0);
    wr(rgb_led_pkg::CTRL_ADDR, 8'h4e);
    $display("Test direct done");
    wr(rgb_led_pkg::FLASH_ADDR, 8'h40);
    cyc(2);
    chkLeds(3'h7);
    wr(rgb_led_pkg::GPIO_ADDR, 8'h01);
    cyc(2);
    chkLeds(3'h3);
    i_pulse.drive(1'b1);
    cyc(2);
    chkLeds(3'h7);
    wr(rgb_led_pkg::COLOR_ADDR, 8'h0e);
    wr(rgb_led_pkg::CTRL_ADDR, 8'hce);
    countRed(16);
    chk("modulated", 8'h01, {7'h00, ones > 0 && ones < 16});
    i_pulse.drive(1'b0);
    countRed(16);
    chk("gated", 8'h00, 8'(ones));
    $display("Test modulation done");
    wr(rgb_led_pkg::CTRL_ADDR, 8'h4e);
    wr(rgb_led_pkg::SCALE_ADDR, 8'h00);
    wr(rgb_led_pkg::FLASH_ADDR, 8'hf0);
    cyc(2);
    chkLeds(3'h7);
    flashShot(3'h7);
    flashShot(3'h0);
    wr(rgb_led_pkg::FLASH_ADDR, 8'h70);
    wr(rgb_led_pkg::FLASH_ADDR, 8'hf0);
    cyc(2);
    flashShot(3'h7);
    $display("Test flash done");
    wr(rgb_led_pkg::FLASH_ADDR, 8'h01);
    cyc(60);
    wr(rgb_led_pkg::SCALE_ADDR, 8'h3f);
    cyc(60);
    chkLeds(3'h7);
    cyc(50);
    chkLeds(3'h6);
    chkReg(rgb_led_pkg::STATUS_ADDR, 8'h01);
    wr(rgb_led_pkg::SCALE_ADDR, 8'h3f);
    cyc(2);
    chkLeds(3'h6);
    wr(rgb_led_pkg::FLASH_ADDR, 8'h00);
    cyc(2);
    chkLeds(3'h7);
    wr(rgb_led_pkg::FLASH_ADDR, 8'h81);
    i_pulse.drive(1'b1);
    cyc(60);
    i_pulse.drive(1'b0);
    cyc(60);
    chkLeds(3'h7);
    i_pulse.drive(1'b1);
    cyc(50);
    chkLeds(3'h6);
    i_pulse.drive(1'b0);
    $display("Test safety done");
    nrst = 1'b0;
    cyc(3);
    nrst = 1'b1;
    chkLeds(3'h0);
    chk("sink mode", 8'h01, {7'h00, sinkSwitchMode});
    chkReg(rgb_led_pkg::STATUS_ADDR, 8'h00);
    chkReg(rgb_led_pkg::FLASH_ADDR, rgb_led_pkg::FLASH_RESET);
    chkReg(rgb_led_pkg::CTRL_ADDR, rgb_led_pkg::CTRL_RESET);
    $display("Test second reset done");
    tally_and_finish();
  end
endmodule
